//--- core/tag_memory_access_guard.sv
// tag memory access guard: block store, lock bits, passwords, master key modes
//
// Behaviour
// [RULE1] valid write programs 33 bits, data plus lock, in any section
// [RULE2] block with lock bit 1 refuses any further programming
// [RULE3] system section sits at top of 6-bit address space, user below
// [RULE4] configuration from block 63, page security from block 62
// [RULE5] key 0110: traceability and config always readable, traceability never writable
// [RULE6] identifier msb aligned in blocks 56-58, length 16..96, default 64
// [RULE7] identifier compare from bit 31 of block 56 down to length or block 58 bit 0
// [RULE8] passwords in blocks 54 and 55; pages protected for write or read+write
// [RULE9] read and write logins are granted independently
// [RULE10] login compares 32-bit password against store matching its type
// [RULE11] login match acks with bare frame start, mismatch adds error code
// [RULE12] protected write without write login gives error after the command
// [RULE13] reading a password block returns all zero with no error
// [RULE14] key 0110: system blocks use fixed rights, password blocks need login
// [RULE15] keys 6 and 9 enable modes and protection; 9 and others enable clear
// [RULE16] key 0: every unlocked block readable and writable regardless of pages
// [RULE17] once config block is locked, it and other locked blocks stay fixed
// [RULE18] config shadow reloads on power-on, reset-to-ready and writes to 63
// [RULE19] delivered state: all zero except traceability, key 0; the code also presets config block 63 to identifier length 64
// [RULE20] 200 field clocks after power-up, configuration and page security loaded
// [RULE21] user memory is 8 pages of 4 blocks, the page security units
// [RULE22] rejected writes leave block data and lock bit unchanged
`timescale 1ns/1ps
module tag_memory_access_guard
    import tag_guard_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_field_clk,
    input  wire logic        i_cmd_valid,
    input  wire cmd_t        i_cmd,
    input  wire logic [6:0]  i_id_bit_index,
    output logic             o_ready,
    output logic             o_rsp_valid,
    output rsp_t             o_rsp,
    output logic             o_id_bit,
    output logic             o_id_bit_last,
    output cfg_t             o_cfg,
    output logic             o_rate_option_en,
    output logic             o_user_clear_en,
    output logic             o_public_readonly_mode,
    output logic             o_article_surveillance_mode
);
    // link-side state runs on the field clock; the reference domain only sees a synced response toggle and the held response
    logic [31:0] mem_data [N_BLOCKS];
    logic        mem_lock [N_BLOCKS];
    logic [INIT_W-1:0] init_cnt_reg;
    logic        init_done_reg;
    logic        cmd_tgl_reg;
    cmd_t        cmd_hold_reg;
    logic        rsp_tgl_reg;
    rsp_t        rsp_hold_reg;
    cfg_t        shadow_reg;
    logic [31:0] psec_reg;
    logic        login_rd_reg;
    logic        login_wr_reg;
    logic        ctgl_s1_reg, ctgl_s2_reg, ctgl_s3_reg;
    logic        rtgl_s1_reg, rtgl_s2_reg, rtgl_s3_reg;
    logic        busy_reg;
    logic        cmd_strobe;

    // reference domain: capture command, toggle toward field domain
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmd_tgl_reg  <= 1'b0;
            cmd_hold_reg <= '0;
            busy_reg     <= 1'b0;
        end else if (i_cmd_valid && !busy_reg) begin
            cmd_hold_reg <= i_cmd;
            cmd_tgl_reg  <= ~cmd_tgl_reg;
            busy_reg     <= 1'b1;
        end else if (rtgl_s3_reg != rtgl_s2_reg) begin
            busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rtgl_s1_reg <= 1'b0;
            rtgl_s2_reg <= 1'b0;
            rtgl_s3_reg <= 1'b0;
        end else begin
            rtgl_s1_reg <= rsp_tgl_reg;
            rtgl_s2_reg <= rtgl_s1_reg;
            rtgl_s3_reg <= rtgl_s2_reg;
        end
    end

    // response held stable in field domain until next command, so a plain copy is safe here
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rsp_valid <= 1'b0;
            o_rsp       <= '0;
            o_ready     <= 1'b0;
        end else begin
            o_rsp_valid <= (rtgl_s3_reg != rtgl_s2_reg);
            if (rtgl_s3_reg != rtgl_s2_reg) begin
                o_rsp <= rsp_hold_reg;
            end
            o_ready <= !busy_reg && !(i_cmd_valid && !busy_reg);
        end
    end

    // field domain
    always_ff @(posedge i_field_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctgl_s1_reg <= 1'b0;
            ctgl_s2_reg <= 1'b0;
            ctgl_s3_reg <= 1'b0;
        end else begin
            ctgl_s1_reg <= cmd_tgl_reg;
            ctgl_s2_reg <= ctgl_s1_reg;
            ctgl_s3_reg <= ctgl_s2_reg;
        end
    end
    assign cmd_strobe = (ctgl_s3_reg != ctgl_s2_reg) && init_done_reg;

    // power-up delay; commands arriving before it ends are dropped
    always_ff @(posedge i_field_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            init_cnt_reg  <= '0;
            init_done_reg <= 1'b0;
        end else if (!init_done_reg) begin
            init_cnt_reg <= init_cnt_reg + 1'b1;
            if (init_cnt_reg == INIT_W'(INIT_CYCLES - 1)) begin
                init_done_reg <= 1'b1; // RULE20
            end
        end
    end

    logic [3:0] key;
    logic       prot_on;
    logic [2:0] page;
    logic       is_user;
    logic       wr_page_prot, rd_page_prot;
    logic       is_pw, is_trace, is_sys;
    logic       rd_ok, wr_ok;
    assign key      = shadow_reg.key;
    assign prot_on  = (key == KEY_SAFE) || (key == KEY_FULL); // RULE15
    assign page     = cmd_hold_reg.addr[4:2]; // RULE21
    assign is_user  = cmd_hold_reg.addr < 6'(USER_BLOCKS); // RULE3
    assign is_sys   = cmd_hold_reg.addr >= SYS_BASE; // RULE3
    assign is_pw    = (cmd_hold_reg.addr == BLK_READ_PW) || (cmd_hold_reg.addr == BLK_WRITE_PW); // RULE8
    assign is_trace = (cmd_hold_reg.addr >= BLK_TRACE_FIRST) && (cmd_hold_reg.addr <= BLK_TRACE_LAST);
    assign wr_page_prot = psec_reg[PSEC_WR_LSB + page] | psec_reg[PSEC_RD_LSB + page]; // RULE8
    assign rd_page_prot = psec_reg[PSEC_RD_LSB + page]; // RULE8

    always_comb begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
        if (prot_on) begin
            if (is_user) begin
                rd_ok = !rd_page_prot || login_rd_reg; // RULE9
                wr_ok = !wr_page_prot || login_wr_reg; // RULE12
            end else if (is_sys) begin
                // fixed system rights, page security ignored
                if (is_trace || cmd_hold_reg.addr == BLK_CONFIG) begin
                    rd_ok = 1'b1; // RULE5
                end else begin
                    rd_ok = login_rd_reg; // RULE14
                end
                wr_ok = !is_trace && login_wr_reg; // RULE5 RULE14
            end
        end
        // key 0 and others: unlocked blocks open
    end

    logic [31:0] rd_data;
    logic        write_go;
    assign rd_data  = is_pw ? 32'h0000_0000 : mem_data[cmd_hold_reg.addr]; // RULE13
    assign write_go = cmd_strobe && (cmd_hold_reg.op == CMD_WRITE) && wr_ok
                      && !mem_lock[cmd_hold_reg.addr]; // RULE2 RULE16 RULE17 RULE22

    // block store: all zero except config id length 64, traceability locked; locked blocks never change
    always_ff @(posedge i_field_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int b = 0; b < N_BLOCKS; b++) begin
                mem_data[b] <= 32'h0000_0000; // RULE19
                mem_lock[b] <= 1'b0;
            end
            for (int b = BLK_TRACE_FIRST; b <= BLK_TRACE_LAST; b++) begin
                mem_data[b] <= TRACE_DEFAULT;
                mem_lock[b] <= 1'b1;
            end
            mem_data[BLK_CONFIG] <= 32'(IDLEN_DEFAULT); // RULE6
        end else if (write_go) begin
            mem_data[cmd_hold_reg.addr] <= cmd_hold_reg.data; // RULE1
            mem_lock[cmd_hold_reg.addr] <= cmd_hold_reg.lock; // RULE1
        end
    end

    // shadow config and page security; the store updates on the same edge, so a config write loads the new word
    logic [31:0] cfg_word;
    assign cfg_word = (write_go && cmd_hold_reg.addr == BLK_CONFIG) ? cmd_hold_reg.data
                                                                    : mem_data[BLK_CONFIG];

    always_ff @(posedge i_field_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            shadow_reg <= '0;
            psec_reg   <= '0;
        end else if ((!init_done_reg && init_cnt_reg == '0)
                     || (cmd_strobe && cmd_hold_reg.op == CMD_RESET_READY)
                     || (write_go && cmd_hold_reg.addr == BLK_CONFIG)) begin // RULE18
            shadow_reg.key  <= cfg_word[CFG_KEY_LSB +: 4]; // RULE4
            shadow_reg.ddr  <= cfg_word[CFG_DDR_BIT];
            shadow_reg.public_readonly_mode      <= cfg_word[CFG_PUBLIC_BIT];
            shadow_reg.article_surveillance_mode <= cfg_word[CFG_SURV_BIT];
            shadow_reg.id_len <= cfg_word[CFG_IDLEN_LSB +: IDLEN_W];
            psec_reg <= mem_data[BLK_PAGE_SEC]; // RULE4
        end
    end

    // logins; reset-to-ready ends the session
    always_ff @(posedge i_field_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            login_rd_reg <= 1'b0;
            login_wr_reg <= 1'b0;
        end else if (cmd_strobe) begin
            if (cmd_hold_reg.op == CMD_LOGIN_RD) begin
                login_rd_reg <= (cmd_hold_reg.data == mem_data[BLK_READ_PW]); // RULE9 RULE10
            end else if (cmd_hold_reg.op == CMD_LOGIN_WR) begin
                login_wr_reg <= (cmd_hold_reg.data == mem_data[BLK_WRITE_PW]); // RULE9 RULE10
            end else if (cmd_hold_reg.op == CMD_RESET_READY) begin
                login_rd_reg <= 1'b0;
                login_wr_reg <= 1'b0;
            end
        end
    end

    // response per command: err=0 is a bare frame start ack
    always_ff @(posedge i_field_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rsp_tgl_reg  <= 1'b0;
            rsp_hold_reg <= '0;
        end else if (cmd_strobe) begin
            rsp_tgl_reg <= ~rsp_tgl_reg;
            rsp_hold_reg <= '0;
            unique case (cmd_hold_reg.op)
                CMD_READ: begin
                    rsp_hold_reg.err  <= !rd_ok && !is_pw; // RULE13
                    rsp_hold_reg.data <= rd_ok ? rd_data : 32'h0000_0000;
                    rsp_hold_reg.lock <= mem_lock[cmd_hold_reg.addr];
                end
                CMD_WRITE: rsp_hold_reg.err <= !write_go; // RULE12 RULE22
                CMD_LOGIN_RD: rsp_hold_reg.err <= (cmd_hold_reg.data != mem_data[BLK_READ_PW]); // RULE11
                CMD_LOGIN_WR: rsp_hold_reg.err <= (cmd_hold_reg.data != mem_data[BLK_WRITE_PW]); // RULE11
                CMD_RESET_READY: rsp_hold_reg.err <= 1'b0;
                CMD_ID_BIT: rsp_hold_reg.err <= 1'b0;
                default: rsp_hold_reg.err <= 1'b1;
            endcase
        end
    end

    // identifier bit for anticollision, msb of block 56 first
    logic [6:0] id_len_eff;
    logic [1:0] id_blk;
    logic [4:0] id_pos;
    assign id_len_eff = (shadow_reg.id_len < IDLEN_MIN) ? IDLEN_MIN :
                        (shadow_reg.id_len > IDLEN_MAX) ? IDLEN_MAX : shadow_reg.id_len; // RULE6
    assign id_blk = i_id_bit_index[6:5];
    assign id_pos = 5'd31 - i_id_bit_index[4:0];

    always_ff @(posedge i_field_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_id_bit      <= 1'b0;
            o_id_bit_last <= 1'b0;
        end else begin
            o_id_bit <= (id_blk == 2'd3) ? 1'b0 : mem_data[BLK_ID_FIRST + 6'(id_blk)][id_pos]; // RULE7
            o_id_bit_last <= (i_id_bit_index + 7'd1 >= id_len_eff); // RULE7
        end
    end

    // mode enables from the shadow
    always_ff @(posedge i_field_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_cfg                       <= '0;
            o_rate_option_en            <= 1'b0;
            o_user_clear_en             <= 1'b0;
            o_public_readonly_mode      <= 1'b0;
            o_article_surveillance_mode <= 1'b0;
        end else begin
            o_cfg                       <= shadow_reg;
            o_rate_option_en            <= prot_on && shadow_reg.ddr; // RULE15
            o_user_clear_en             <= (key != KEY_SAFE); // RULE15
            o_public_readonly_mode      <= prot_on && shadow_reg.public_readonly_mode;
            o_article_surveillance_mode <= prot_on && shadow_reg.article_surveillance_mode;
        end
    end

    // store, lock bits and init
    locked_stays_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE2
        mem_lock[cmd_hold_reg.addr] |=> mem_lock[$past(cmd_hold_reg.addr)])
        else $error("locked block lost lock");
    lock_data_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE22
        cmd_strobe && mem_lock[cmd_hold_reg.addr]
        |=> mem_data[$past(cmd_hold_reg.addr)] == $past(mem_data[cmd_hold_reg.addr]))
        else $error("locked block data changed");
    write_lock_err_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE22
        cmd_strobe && cmd_hold_reg.op == CMD_WRITE && mem_lock[cmd_hold_reg.addr] |=> rsp_hold_reg.err)
        else $error("write to locked block not refused");
    init_drop_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE20
        !init_done_reg |-> !write_go)
        else $error("write before init done");
    init_delay_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE20
        $rose(init_done_reg) |-> init_cnt_reg == INIT_W'(INIT_CYCLES))
        else $error("init delay wrong");
    cfg_reload_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE18
        write_go && cmd_hold_reg.addr == BLK_CONFIG
        |=> shadow_reg.key == $past(cmd_hold_reg.data[31:28]))
        else $error("shadow not reloaded");

    // access rights
    trace_nowrite_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE5
        prot_on && is_trace |-> !wr_ok)
        else $error("traceability writable");
    trace_read_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE5
        prot_on && (is_trace || cmd_hold_reg.addr == BLK_CONFIG) |-> rd_ok)
        else $error("traceability or config unreadable");
    sys_login_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE14
        prot_on && is_sys && !is_trace && cmd_hold_reg.addr != BLK_CONFIG && !login_rd_reg
        |-> !rd_ok)
        else $error("system block readable without login");
    key0_open_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE16
        key == KEY_OPEN |-> rd_ok && wr_ok)
        else $error("key zero restricted access");
    prot_write_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE12
        prot_on && is_user && wr_page_prot && !login_wr_reg |-> !wr_ok)
        else $error("protected write allowed");
    refused_write_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE12
        cmd_strobe && cmd_hold_reg.op == CMD_WRITE && !wr_ok |=> rsp_hold_reg.err)
        else $error("refused write not flagged");
    rd_refuse_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE9
        cmd_strobe && cmd_hold_reg.op == CMD_READ && !rd_ok && !is_pw
        |=> rsp_hold_reg.err && rsp_hold_reg.data == 32'h0000_0000)
        else $error("refused read not flagged");

    // logins and replies
    pw_read_zero_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE13
        cmd_strobe && cmd_hold_reg.op == CMD_READ && is_pw |=> rsp_hold_reg.data == 32'h0 && !rsp_hold_reg.err)
        else $error("password read not zero");
    login_ack_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE11
        cmd_strobe && cmd_hold_reg.op == CMD_LOGIN_WR |=> rsp_hold_reg.err == !login_wr_reg)
        else $error("login ack mismatch");
    login_indep_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE9
        cmd_strobe && cmd_hold_reg.op == CMD_LOGIN_RD |=> login_wr_reg == $past(login_wr_reg))
        else $error("read login changed write login");

    // identifier and mode outputs
    id_first_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE7
        i_id_bit_index == 7'h00 |=> o_id_bit == $past(mem_data[BLK_ID_FIRST][31]))
        else $error("identifier msb wrong");
    id_last_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE7
        i_id_bit_index == 7'h5F |=> o_id_bit_last)
        else $error("identifier end missed");
    mode_gate_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE15
        o_rate_option_en || o_public_readonly_mode || o_article_surveillance_mode
        |-> o_cfg.key == KEY_SAFE || o_cfg.key == KEY_FULL)
        else $error("mode enabled without protection key");
    clear_gate_a: assert property (@(posedge i_field_clk) disable iff (!i_rstn) // RULE15
        o_cfg.key == KEY_SAFE |-> !o_user_clear_en)
        else $error("user clear enabled with safe key");

    // main scenarios
    cov_write_c: cover property (@(posedge i_field_clk) write_go);
    cov_login_c: cover property (@(posedge i_field_clk) cmd_strobe && cmd_hold_reg.op == CMD_LOGIN_RD);
    cov_refuse_c: cover property (@(posedge i_field_clk) cmd_strobe && cmd_hold_reg.op == CMD_WRITE && !write_go);
    cov_reload_c: cover property (@(posedge i_field_clk) cmd_strobe && cmd_hold_reg.op == CMD_RESET_READY);
    cov_lock_c: cover property (@(posedge i_field_clk) write_go && cmd_hold_reg.lock);
endmodule : tag_memory_access_guard

//--- core/tag_guard_pkg.sv
// package: memory map, config fields, keys, commands and timing for the tag access guard
package tag_guard_pkg;
    localparam int          BLK_W            = 32;
    localparam int          ADDR_W           = 6;
    localparam int          N_BLOCKS         = 64;
    localparam int          USER_BLOCKS      = 32;
    localparam int          PAGE_BLOCKS      = 4;
    localparam int          N_PAGES          = 8;
    localparam logic [5:0]  SYS_BASE         = 6'h36;
    localparam logic [5:0]  BLK_READ_PW      = 6'h36;
    localparam logic [5:0]  BLK_WRITE_PW     = 6'h37;
    localparam logic [5:0]  BLK_ID_FIRST     = 6'h38;
    localparam logic [5:0]  BLK_ID_LAST      = 6'h3A;
    localparam logic [5:0]  BLK_TRACE_FIRST  = 6'h3B;
    localparam logic [5:0]  BLK_TRACE_LAST   = 6'h3D;
    localparam logic [5:0]  BLK_PAGE_SEC     = 6'h3E;
    localparam logic [5:0]  BLK_CONFIG       = 6'h3F;
    // config block field positions
    localparam int          CFG_KEY_LSB      = 28;
    localparam int          CFG_DDR_BIT      = 27;
    localparam int          CFG_PUBLIC_BIT   = 26;
    localparam int          CFG_SURV_BIT     = 25;
    localparam int          CFG_IDLEN_LSB    = 0;
    localparam int          IDLEN_W          = 7;
    // page security block: bits [7:0] write-protect pages, [15:8] read+write protect
    localparam int          PSEC_WR_LSB      = 0;
    localparam int          PSEC_RD_LSB      = 8;
    localparam logic [3:0]  KEY_SAFE         = 4'h6;
    localparam logic [3:0]  KEY_FULL         = 4'h9;
    localparam logic [3:0]  KEY_OPEN         = 4'h0;
    localparam logic [6:0]  IDLEN_MIN        = 7'h10;
    localparam logic [6:0]  IDLEN_MAX        = 7'h60;
    localparam logic [6:0]  IDLEN_DEFAULT    = 7'h40;
    localparam logic [31:0] TRACE_DEFAULT    = 32'h0000_0000;
    localparam int          INIT_CYCLES      = 200;
    localparam int          INIT_W           = 8;

    typedef enum logic [2:0] {
        CMD_READ, CMD_WRITE, CMD_LOGIN_RD, CMD_LOGIN_WR, CMD_RESET_READY, CMD_ID_BIT
    } cmd_op_t;

    typedef struct packed {
        logic [2:0]  op;
        logic [5:0]  addr;
        logic [31:0] data;
        logic        lock;
    } cmd_t;

    typedef struct packed {
        logic        err;
        logic [31:0] data;
        logic        lock;
    } rsp_t;

    typedef struct packed {
        logic [3:0]  key;
        logic        ddr;
        logic        public_readonly_mode;
        logic        article_surveillance_mode;
        logic [6:0]  id_len;
    } cfg_t;
endpackage : tag_guard_pkg

//--- bench/reader_model.sv
// interrogator model: one downlink command at a time, reply collected on the reference clock
`timescale 1ns/1ps
module reader_model
    import tag_guard_pkg::*;
(
    input  wire logic i_ref_clk,
    input  wire logic i_ready,
    input  wire logic i_rsp_valid,
    input  wire rsp_t i_rsp,
    output logic      o_cmd_valid,
    output cmd_t      o_cmd
);
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd       = '0;
    end

    // whole 33-bit block or 32-bit password per command, held until taken
    task automatic send(input logic [2:0] op, input logic [5:0] addr, input logic [31:0] data,
                        input logic lock, output rsp_t rsp, output bit ok);
        ok  = 1'b0;
        rsp = '0;
        @(posedge i_ref_clk);
        #1;
        o_cmd_valid = 1'b1;
        o_cmd       = '{op: op, addr: addr, data: data, lock: lock};
        for (int n = 0; n < 50; n++) begin
            @(posedge i_ref_clk);
            if (i_ready === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
        #1;
        o_cmd_valid = 1'b0;
        // stale fields scrambled so the tag cannot lean on them
        o_cmd       = ~o_cmd;
        if (ok) begin
            ok = 1'b0;
            for (int n = 0; n < 400; n++) begin
                @(posedge i_ref_clk);
                if (i_rsp_valid === 1'b1) begin
                    rsp = i_rsp;
                    ok  = 1'b1;
                    break;
                end
            end
            repeat (2) @(posedge i_ref_clk);
        end
    endtask : send
endmodule : reader_model

//--- bench/tag_memory_access_guard_bench.sv
// bench for the tag access guard: command sequences with expected replies and outputs
`timescale 1ns/1ps
module tag_memory_access_guard_bench;
    import tag_guard_pkg::*;
    logic       ref_clk, field_clk, rstn, cmd_valid, ready, rsp_valid;
    logic       id_bit, id_bit_last, rate_en, clear_en, pub_mode, surv_mode;
    logic [6:0] id_idx;
    cmd_t       cmd;
    rsp_t       rsp;
    cfg_t       cfg;
    int         n_fail     = 0;
    int         n_compared = 0;

    tag_memory_access_guard u_tag_memory_access_guard (
        .i_ref_clk(ref_clk), .i_rstn(rstn), .i_field_clk(field_clk), .i_cmd_valid(cmd_valid),
        .i_cmd(cmd), .i_id_bit_index(id_idx), .o_ready(ready), .o_rsp_valid(rsp_valid), .o_rsp(rsp),
        .o_id_bit(id_bit), .o_id_bit_last(id_bit_last), .o_cfg(cfg), .o_rate_option_en(rate_en),
        .o_user_clear_en(clear_en), .o_public_readonly_mode(pub_mode),
        .o_article_surveillance_mode(surv_mode));
    reader_model u_reader_model (.i_ref_clk(ref_clk), .i_ready(ready), .i_rsp_valid(rsp_valid),
        .i_rsp(rsp), .o_cmd_valid(cmd_valid), .o_cmd(cmd));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // field clock phase offset on purpose
    initial begin
        field_clk = 1'b0;
        #3.3;
        forever #7.5 field_clk = ~field_clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results

    task automatic op(input logic [2:0] o, input logic [5:0] a, input logic [31:0] d, input logic l,
                      output rsp_t r);
        bit ok;
        u_reader_model.send(o, a, d, l, r, ok);
        if (!ok) begin
            n_fail++;
            $display("Error at %0t: no reply, seen 0x%h expected 0x%h", $time, 1'b0, 1'b1);
            results();
        end
    endtask : op

    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic l, input logic e);
        rsp_t r;
        op(CMD_WRITE, a, d, l, r);
        check(r.err, e);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic e, input logic [31:0] d, input logic l);
        rsp_t r;
        op(CMD_READ, a, 32'h0000_0000, 1'b0, r);
        check({r.err, r.data, r.lock}, {e, d, l});
    endtask : rd

    task automatic login(input logic [2:0] o, input logic [31:0] pw, input logic e);
        rsp_t r;
        op(o, 6'h00, pw, 1'b0, r);
        check(r.err, e);
    endtask : login

    task automatic cfg_chk(input logic [3:0] k, input logic [6:0] len, input logic rate, input logic clr);
        repeat (10) @(posedge ref_clk);
        check({cfg.key, cfg.id_len, rate_en, pub_mode, surv_mode, clear_en}, {k, len, {3{rate}}, clr});
    endtask : cfg_chk

    task automatic id_chk(input logic [6:0] idx, input logic [1:0] e);
        @(posedge field_clk);
        #1;
        id_idx = idx;
        repeat (3) @(posedge field_clk);
        #1;
        check({id_bit, id_bit_last}, e);
    endtask : id_chk

    // config word: key, rate, public and surveillance bits set, identifier length 32
    function automatic logic [31:0] cw(input logic [3:0] k);
        cw = {k, 3'b111, 18'h0_0000, 7'h20};
    endfunction : cw

    initial begin
        rsp_t r;
        rstn   = 1'b0;
        id_idx = 7'h00;
        repeat (12) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        // commands before init completes are dropped
        repeat (700) @(posedge ref_clk);
        cfg_chk(KEY_OPEN, IDLEN_DEFAULT, 1'b0, 1'b1);
        rd(6'h3B, 1'b0, TRACE_DEFAULT, 1'b1);
        op(CMD_WRITE, 6'h3B, 32'hAAAA_5555, 1'b0, r);
        rd(6'h3B, 1'b0, TRACE_DEFAULT, 1'b1);
        $display("test delivered state done");
        wr(6'h05, 32'h1234_5678, 1'b0, 1'b0);
        rd(6'h05, 1'b0, 32'h1234_5678, 1'b0);
        wr(6'h06, 32'hCAFE_0001, 1'b1, 1'b0);
        op(CMD_WRITE, 6'h06, 32'hFFFF_FFFF, 1'b0, r);
        rd(6'h06, 1'b0, 32'hCAFE_0001, 1'b1);
        wr(6'h36, 32'h1111_2222, 1'b0, 1'b0);
        wr(6'h37, 32'h3333_4444, 1'b0, 1'b0);
        rd(6'h36, 1'b0, 32'h0000_0000, 1'b0);
        wr(6'h38, 32'h8000_0001, 1'b0, 1'b0);
        id_chk(7'h00, 2'b10);
        id_chk(7'h1F, 2'b10);
        id_chk(7'h3F, 2'b01);
        id_chk(7'h5F, 2'b01);
        $display("test open key done");
        wr(6'h3E, 32'h0000_0402, 1'b0, 1'b0);
        wr(6'h3F, cw(KEY_SAFE), 1'b0, 1'b0);
        cfg_chk(KEY_SAFE, 7'h20, 1'b1, 1'b0);
        wr(6'h04, 32'hDEAD_0004, 1'b0, 1'b1);
        rd(6'h04, 1'b0, 32'h0000_0000, 1'b0);
        rd(6'h08, 1'b1, 32'h0000_0000, 1'b0);
        rd(6'h03, 1'b0, 32'h0000_0000, 1'b0);
        login(CMD_LOGIN_RD, 32'h3333_4444, 1'b1);
        login(CMD_LOGIN_RD, 32'h1111_2222, 1'b0);
        rd(6'h08, 1'b0, 32'h0000_0000, 1'b0);
        wr(6'h08, 32'h0000_0008, 1'b0, 1'b1);
        rd(6'h3B, 1'b0, TRACE_DEFAULT, 1'b1);
        rd(6'h3F, 1'b0, cw(KEY_SAFE), 1'b0);
        rd(6'h36, 1'b0, 32'h0000_0000, 1'b0);
        op(CMD_RESET_READY, 6'h00, 32'h0000_0000, 1'b0, r);
        rd(6'h08, 1'b1, 32'h0000_0000, 1'b0);
        rd(6'h37, 1'b0, 32'h0000_0000, 1'b0);
        login(CMD_LOGIN_WR, 32'h3333_4444, 1'b0);
        wr(6'h04, 32'hDEAD_0004, 1'b0, 1'b0);
        rd(6'h04, 1'b0, 32'hDEAD_0004, 1'b0);
        $display("test safe key done");
        wr(6'h3F, cw(KEY_FULL), 1'b0, 1'b0);
        cfg_chk(KEY_FULL, 7'h20, 1'b1, 1'b1);
        wr(6'h3F, cw(4'h3), 1'b0, 1'b0);
        cfg_chk(4'h3, 7'h20, 1'b0, 1'b1);
        $display("test key table done");
        wr(6'h3F, cw(KEY_OPEN), 1'b1, 1'b0);
        op(CMD_WRITE, 6'h3F, cw(KEY_SAFE), 1'b0, r);
        cfg_chk(KEY_OPEN, 7'h20, 1'b0, 1'b1);
        op(CMD_RESET_READY, 6'h00, 32'h0000_0000, 1'b0, r);
        cfg_chk(KEY_OPEN, 7'h20, 1'b0, 1'b1);
        $display("test double lock done");
        results();
    end
endmodule : tag_memory_access_guard_bench
